// file: include/dma_queue_consts.svh
// Register offsets, field positions and reset values of the DMA queue event block.
`ifndef DMA_QUEUE_CONSTS_SVH
`define DMA_QUEUE_CONSTS_SVH

// Register byte offsets inside the soft register window.
`define DQ_OFS_QSIZE      8'h14
`define DQ_OFS_DESC_PTR   8'h18
`define DQ_OFS_STAT_PTR   8'h1C
`define DQ_OFS_SEVERITY   8'h20
`define DQ_OFS_ENABLE     8'h24
`define DQ_OFS_MASK       8'h28
`define DQ_OFS_STATUS     8'h2C
`define DQ_OFS_FUNCS      8'h40
`define DQ_OFS_BURST      8'h44

// Event bit positions, shared by severity, enable, mask and status.
`define DQ_EV_DESC_UPD    0
`define DQ_EV_DESC_EMPTY  1
`define DQ_EV_DESC_FULL   2
`define DQ_EV_STAT_UPD    4
`define DQ_EV_STAT_EMPTY  5
`define DQ_EV_STAT_FULL   6
`define DQ_EV_W           7
`define DQ_EV_VALID       7'h77

// Field positions inside the queue size and pointer registers.
`define DQ_LO_PTR_LSB     0
`define DQ_HI_PTR_LSB     16
`define DQ_PTR_W          8
`define DQ_SIZE_W         9
`define DQ_FUNCS_W        3
`define DQ_BURST_W        7

// Reset values.
`define DQ_RST_EVENTS     7'h00
`define DQ_RST_PTR        8'h00
`define DQ_RST_BURST      7'h08
`define DQ_DEF_QSIZE      9'h020
`define DQ_DEF_FUNCS      3'h1

// Burst length of the lowest one-hot setting, in beats.
`define DQ_BURST_BASE     16'h0004
`define DQ_BEATS_W        16

`endif

// file: include/dma_queue_pkg.sv
// Types shared by the DMA queue event block, its DMA master model and its bench.
package dma_queue_pkg;

  typedef logic [6:0] evt_t;

  // One burst command handed to the bus master side.
  typedef struct packed {
    logic [15:0] beats;
    logic        last;
  } burst_cmd_s;

  // Queue pointer snapshot shown to the user side.
  typedef struct packed {
    logic [7:0] desc_rptr;
    logic [7:0] desc_wptr;
    logic [7:0] stat_rptr;
    logic [7:0] stat_wptr;
  } queue_ptrs_s;

  typedef enum logic [0:0] {
    SPLIT_IDLE = 1'b0,
    SPLIT_BUSY = 1'b1
  } split_state_e;

endpackage : dma_queue_pkg

// file: hw/event_flag_cell.sv
// Sticky event flags with enable gating and write-one-to-clear.
`timescale 1ns/1ns
module event_flag_cell #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Event side
  input  wire logic [WIDTH-1:0] set_evt,
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] clear,
  // Flags
  output logic      [WIDTH-1:0] flag_r
);

  // A disabled flag is held at zero; otherwise a set beats a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= enable & (set_evt | (flag_r & ~clear));
    end
  end

endmodule : event_flag_cell

// file: hw/dma_queue_interrupt_csr.sv
// DMA queue pointers, queue event flags, interrupt outputs and burst splitting.
//
// Notes on behaviour
// - After posting a status entry the status write pointer advances, wrapping at size-1.
// - Severity bits 6,5,4,2,1,0 classify each event: 0 normal, 1 critical.
// - Normal interrupt rises when any enabled unmasked normal event is set.
// - Critical interrupt rises when any enabled unmasked critical event is set.
// - A cleared enable bit holds that event's status at zero.
// - A set mask bit keeps the event off both interrupts but still recorded.
// - Status bit 6 flags status queue full; write 1 clears.
// - Status bit 5 flags status queue empty; write 1 clears.
// - Status bit 4 flags a status write pointer change; write 1 clears.
// - Status bit 2 flags descriptor queue full; bit 3 and 31:7 read zero.
// - Status bit 1 flags descriptor queue empty; write 1 clears.
// - Status bit 0 flags a descriptor read pointer change; write 1 clears.
// - Three-bit function count field, reset from a build parameter.
// - One-hot burst limit, 01h is 4 beats up to 40h is 256, resets 08h.
// - Requests beyond the burst limit go out as several limited transactions.
// - Empty when pointers match, full when write pointer is one behind read.
`timescale 1ns/1ns
`include "dma_queue_consts.svh"
module dma_queue_interrupt_csr #(
  parameter logic [8:0] DESC_QUEUE_SIZE = `DQ_DEF_QSIZE,
  parameter logic [8:0] STAT_QUEUE_SIZE = `DQ_DEF_QSIZE,
  parameter logic [2:0] NUM_FUNCTIONS   = `DQ_DEF_FUNCS
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // APB register slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // DMA engine events
  input  wire logic                      desc_fetch,
  input  wire logic                      stat_post,
  // Interrupts
  output logic                           int_normal,
  output logic                           int_critical,
  // Queue state
  output dma_queue_pkg::queue_ptrs_s     queue_ptrs,
  output logic [2:0]                     func_count,
  // Transfer request in, burst commands out
  input  wire logic                      req_valid,
  input  wire logic [15:0]               req_beats,
  output logic                           req_ready,
  output logic                           burst_valid,
  output dma_queue_pkg::burst_cmd_s      burst_cmd,
  input  wire logic                      burst_ready
);

  // Register state.
  dma_queue_pkg::evt_t           sev_r;
  dma_queue_pkg::evt_t           en_r;
  dma_queue_pkg::evt_t           mask_r;
  dma_queue_pkg::evt_t           status_r;
  logic [`DQ_SIZE_W-1:0]         descq_size_r;
  logic [`DQ_SIZE_W-1:0]         statq_size_r;
  logic [`DQ_PTR_W-1:0]          desc_rptr_r;
  logic [`DQ_PTR_W-1:0]          desc_wptr_r;
  logic [`DQ_PTR_W-1:0]          stat_rptr_r;
  logic [`DQ_PTR_W-1:0]          stat_wptr_r;
  logic [`DQ_FUNCS_W-1:0]        funcs_r;
  logic [`DQ_BURST_W-1:0]        burst_lim_r;
  logic                          int_normal_r;
  logic                          int_critical_r;

  // Bus decode.
  logic                          wr_en;
  logic                          rd_en;
  logic                          addr_hit;
  logic [31:0]                   rd_data;

  // Queue conditions and events.
  logic                          desc_empty;
  logic                          desc_full;
  logic                          stat_empty;
  logic                          stat_full;
  dma_queue_pkg::evt_t           ev_set;
  dma_queue_pkg::evt_t           ev_clr;

  // Burst splitter.
  dma_queue_pkg::split_state_e   split_r;
  logic [`DQ_BEATS_W-1:0]        remain_r;
  logic [`DQ_BEATS_W-1:0]        max_beats;
  logic [`DQ_BEATS_W-1:0]        remain_nxt;

  // Advance a pointer, wrapping to zero once it equals size minus one.
  function automatic logic [7:0] ptr_step(input logic [7:0] ptr, input logic [8:0] size);
    logic [8:0] last;
    last = size - 9'h001;
    if ({1'b0, ptr} == last) begin
      ptr_step = 8'h00;
    end else begin
      ptr_step = ptr + 8'h01;
    end
  endfunction : ptr_step

  // The APB slave answers every access in its access phase with no wait states.
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // Read multiplexer; reserved bits, and an unmapped address, read as zero.
  always_comb begin
    addr_hit = 1'b1;
    rd_data  = 32'h0000_0000;
    case (paddr)
      `DQ_OFS_QSIZE: begin
        rd_data[`DQ_HI_PTR_LSB +: `DQ_SIZE_W] = statq_size_r;
        rd_data[`DQ_LO_PTR_LSB +: `DQ_SIZE_W] = descq_size_r;
      end
      `DQ_OFS_DESC_PTR: begin
        rd_data[`DQ_HI_PTR_LSB +: `DQ_PTR_W] = desc_rptr_r;
        rd_data[`DQ_LO_PTR_LSB +: `DQ_PTR_W] = desc_wptr_r;
      end
      `DQ_OFS_STAT_PTR: begin
        rd_data[`DQ_HI_PTR_LSB +: `DQ_PTR_W] = stat_wptr_r;
        rd_data[`DQ_LO_PTR_LSB +: `DQ_PTR_W] = stat_rptr_r;
      end
      `DQ_OFS_SEVERITY: rd_data[`DQ_EV_W-1:0] = sev_r;
      `DQ_OFS_ENABLE:   rd_data[`DQ_EV_W-1:0] = en_r;
      `DQ_OFS_MASK:     rd_data[`DQ_EV_W-1:0] = mask_r;
      `DQ_OFS_STATUS:   rd_data[`DQ_EV_W-1:0] = status_r;
      `DQ_OFS_FUNCS:    rd_data[`DQ_FUNCS_W-1:0] = funcs_r;
      `DQ_OFS_BURST:    rd_data[`DQ_BURST_W-1:0] = burst_lim_r;
      default:          addr_hit = 1'b0;
    endcase
  end

  // Read data is registered so it stands steady through the next setup phase.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_data;
    end
  end

  // Event classification, enable and mask registers; bit 3 is not stored.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sev_r  <= `DQ_RST_EVENTS;
      en_r   <= `DQ_RST_EVENTS;
      mask_r <= `DQ_RST_EVENTS;
    end else if (wr_en) begin
      if (paddr == `DQ_OFS_SEVERITY) begin
        sev_r <= pwdata[`DQ_EV_W-1:0] & `DQ_EV_VALID;
      end
      if (paddr == `DQ_OFS_ENABLE) begin
        en_r <= pwdata[`DQ_EV_W-1:0] & `DQ_EV_VALID;
      end
      if (paddr == `DQ_OFS_MASK) begin
        mask_r <= pwdata[`DQ_EV_W-1:0] & `DQ_EV_VALID;
      end
    end
  end

  // Function count and burst limit; the count comes out of reset at its build value, the limit at 08h.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      funcs_r     <= NUM_FUNCTIONS;
      burst_lim_r <= `DQ_RST_BURST;
    end else if (wr_en) begin
      if (paddr == `DQ_OFS_FUNCS) begin
        funcs_r <= pwdata[`DQ_FUNCS_W-1:0];
      end
      if (paddr == `DQ_OFS_BURST) begin
        burst_lim_r <= pwdata[`DQ_BURST_W-1:0];
      end
    end
  end

  // The build count is a constant, so the register itself carries it out of reset.
  assign func_count = funcs_r;

  // Queue sizes come out of reset at their build values, so the wrap point is right from the first post.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      descq_size_r <= DESC_QUEUE_SIZE;
      statq_size_r <= STAT_QUEUE_SIZE;
    end else if (wr_en && paddr == `DQ_OFS_QSIZE) begin
      statq_size_r <= pwdata[`DQ_HI_PTR_LSB +: `DQ_SIZE_W];
      descq_size_r <= pwdata[`DQ_LO_PTR_LSB +: `DQ_SIZE_W];
    end
  end

  // Pointers the DMA master owns are written by software only.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      desc_wptr_r <= `DQ_RST_PTR;
      stat_rptr_r <= `DQ_RST_PTR;
    end else if (wr_en) begin
      if (paddr == `DQ_OFS_DESC_PTR) begin
        desc_wptr_r <= pwdata[`DQ_LO_PTR_LSB +: `DQ_PTR_W];
      end
      if (paddr == `DQ_OFS_STAT_PTR) begin
        stat_rptr_r <= pwdata[`DQ_LO_PTR_LSB +: `DQ_PTR_W];
      end
    end
  end

  // Pointers the core owns advance on its fetch and post strobes.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      desc_rptr_r <= `DQ_RST_PTR;
      stat_wptr_r <= `DQ_RST_PTR;
    end else begin
      if (desc_fetch) begin
        desc_rptr_r <= ptr_step(desc_rptr_r, descq_size_r);
      end
      if (stat_post) begin
        stat_wptr_r <= ptr_step(stat_wptr_r, statq_size_r);
      end
    end
  end

  // Queue fill levels; one slot stays unused so full and empty differ.
  assign desc_empty = desc_rptr_r == desc_wptr_r;
  assign desc_full  = ptr_step(desc_wptr_r, descq_size_r) == desc_rptr_r;
  assign stat_empty = stat_rptr_r == stat_wptr_r;
  assign stat_full  = ptr_step(stat_wptr_r, statq_size_r) == stat_rptr_r;

  // Event sources and write-one-to-clear strobes for the status flags.
  always_comb begin
    ev_set = '0;
    ev_set[`DQ_EV_STAT_FULL]  = stat_full;
    ev_set[`DQ_EV_STAT_EMPTY] = stat_empty;
    ev_set[`DQ_EV_STAT_UPD]   = stat_post;
    ev_set[`DQ_EV_DESC_FULL]  = desc_full;
    ev_set[`DQ_EV_DESC_EMPTY] = desc_empty;
    ev_set[`DQ_EV_DESC_UPD]   = desc_fetch;
    ev_clr = '0;
    if (wr_en && paddr == `DQ_OFS_STATUS) begin
      ev_clr = pwdata[`DQ_EV_W-1:0];
    end
  end

  // Sticky flags; the unused bit 3 has no enable and so stays zero.
  event_flag_cell #(
    .WIDTH   (`DQ_EV_W)
  ) u_flags (
    .clk_sys (clk_sys),
    .rst     (rst),
    .set_evt (ev_set),
    .enable  (en_r),
    .clear   (ev_clr),
    .flag_r  (status_r)
  );

  // Interrupt lines; a masked flag still shows in status but reaches neither line.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_normal_r   <= 1'b0;
      int_critical_r <= 1'b0;
    end else begin
      int_normal_r   <= |(status_r & en_r & ~mask_r & ~sev_r);
      int_critical_r <= |(status_r & en_r & ~mask_r & sev_r);
    end
  end
  assign int_normal   = int_normal_r;
  assign int_critical = int_critical_r;

  assign queue_ptrs = '{desc_rptr: desc_rptr_r, desc_wptr: desc_wptr_r,
                        stat_rptr: stat_rptr_r, stat_wptr: stat_wptr_r};

  // Beat limit from the one-hot setting; the highest set bit wins, none means 4 beats.
  always_comb begin
    max_beats = `DQ_BURST_BASE;
    for (int i = 0; i < `DQ_BURST_W; i++) begin
      if (burst_lim_r[i]) begin
        max_beats = `DQ_BURST_BASE << i;
      end
    end
  end

  // Remaining beats once the current command is taken.
  assign remain_nxt = remain_r - burst_cmd.beats;

  // Split one request into commands no longer than the limit; the limit is sampled per command.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      split_r   <= dma_queue_pkg::SPLIT_IDLE;
      remain_r  <= '0;
      burst_cmd <= '0;
    end else begin
      case (split_r)
        dma_queue_pkg::SPLIT_IDLE: begin
          if (req_valid && req_beats != '0) begin
            split_r         <= dma_queue_pkg::SPLIT_BUSY;
            remain_r        <= req_beats;
            burst_cmd.beats <= (req_beats > max_beats) ? max_beats : req_beats;
            burst_cmd.last  <= req_beats <= max_beats;
          end
        end
        dma_queue_pkg::SPLIT_BUSY: begin
          if (burst_ready) begin
            remain_r <= remain_nxt;
            if (burst_cmd.last) begin
              split_r <= dma_queue_pkg::SPLIT_IDLE;
            end else begin
              burst_cmd.beats <= (remain_nxt > max_beats) ? max_beats : remain_nxt;
              burst_cmd.last  <= remain_nxt <= max_beats;
            end
          end
        end
        default: split_r <= dma_queue_pkg::SPLIT_IDLE;
      endcase
    end
  end
  assign req_ready   = split_r == dma_queue_pkg::SPLIT_IDLE;
  assign burst_valid = split_r == dma_queue_pkg::SPLIT_BUSY;

  // Checks kept beside the logic they guard.
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_stat_ptr_wrap: assert property (
    stat_post && {1'b0, stat_wptr_r} == statq_size_r - 9'h001 |=> stat_wptr_r == 8'h00)
    else $error("status write pointer did not wrap to zero");

  a_int_normal_out: assert property (
    ##1 int_normal == $past(|(status_r & en_r & ~mask_r & ~sev_r)))
    else $error("normal interrupt disagrees with status");

  a_int_crit_out: assert property (
    (|(status_r & en_r & ~mask_r & sev_r)) |=> int_critical)
    else $error("critical interrupt missing");

  a_enable_holds_zero: assert property (
    ##1 (status_r & ~$past(en_r)) == 7'h00)
    else $error("disabled event flag is set");

  a_mask_records: assert property (
    desc_fetch && en_r == 7'h01 && mask_r[`DQ_EV_DESC_UPD] |=>
    status_r[`DQ_EV_DESC_UPD] ##1 !int_normal && !int_critical)
    else $error("masked event not recorded or raised an interrupt");

  a_reserved_zero: assert property (
    rd_en && paddr == `DQ_OFS_STATUS |=> prdata[31:7] == 25'h0 && !prdata[3])
    else $error("reserved status bits read non-zero");

  a_desc_empty_flag: assert property (
    en_r[`DQ_EV_DESC_EMPTY] && desc_rptr_r == desc_wptr_r |=> status_r[`DQ_EV_DESC_EMPTY])
    else $error("descriptor empty flag not set");

  a_set_beats_clear: assert property (
    stat_post && en_r[`DQ_EV_STAT_UPD] && ev_clr[`DQ_EV_STAT_UPD] |=> status_r[`DQ_EV_STAT_UPD])
    else $error("clear won over a same-cycle event");

  a_burst_limit: assert property (
    burst_valid |-> burst_cmd.beats <= max_beats && burst_cmd.beats != 16'h0000)
    else $error("burst command exceeds the limit");

endmodule : dma_queue_interrupt_csr

// file: verif/dma_master_model.sv
// Partner model: the DMA consumer that takes burst commands from the block.
`timescale 1ns/1ns
module dma_master_model (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // Burst command side
  input  wire logic                      burst_valid,
  input  wire dma_queue_pkg::burst_cmd_s burst_cmd,
  output logic                           burst_ready,
  // Pacing chosen by the bench
  input  wire logic                      slow
);
  dma_queue_pkg::burst_cmd_s got_q[$];
  logic                      tick_r = 1'b0;

  // Ready moves on the falling edge, so it is settled at the consuming edge.
  // A prompt consumer never stalls; a slow one stalls every other cycle.
  always @(negedge clk_sys) begin
    tick_r <= rst ? 1'b0 : ~tick_r;
    burst_ready <= ~slow | tick_r;
  end

  // Every accepted command is logged for the bench to judge.
  always @(posedge clk_sys) begin
    if (!rst && burst_valid === 1'b1 && burst_ready) begin
      got_q.push_back(burst_cmd);
    end
  end
endmodule : dma_master_model

// file: verif/dma_queue_interrupt_csr_tb_top.sv
// Self-checking bench for the DMA queue event, pointer and burst block.
`timescale 1ns/1ns
`include "dma_queue_consts.svh"
`define CHK(g, e) chk(32'(g), 32'(e));
module dma_queue_interrupt_csr_tb_top;
  localparam logic [2:0] NF = 3'h5;
  // Bench-driven inputs, all defined at time zero.
  logic        clk_sys    = 1'b0;
  logic        rst        = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        desc_fetch = 1'b0;
  logic        stat_post  = 1'b0;
  logic        req_valid  = 1'b0;
  logic [15:0] req_beats  = 16'h0;
  logic        slow       = 1'b0;
  // Design outputs and bench state.
  logic [31:0] prdata;
  logic        pready, pslverr, int_normal, int_critical;
  logic        req_ready, burst_valid, burst_ready, last_err;
  logic [2:0]  func_count;
  dma_queue_pkg::queue_ptrs_s queue_ptrs;
  dma_queue_pkg::burst_cmd_s  burst_cmd;
  int          failures    = 0;
  int          checks_done = 0;

  // A status queue of four entries makes the wrap reachable in a few posts.
  dma_queue_interrupt_csr #(.STAT_QUEUE_SIZE(9'h004), .NUM_FUNCTIONS(NF)) u_dut (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .desc_fetch, .stat_post, .int_normal, .int_critical, .queue_ptrs, .func_count,
    .req_valid, .req_beats, .req_ready, .burst_valid, .burst_cmd, .burst_ready);
  dma_master_model u_dma (.clk_sys, .rst, .burst_valid, .burst_cmd, .burst_ready, .slow);

  // Free-running 50 MHz clock.
  initial forever #10 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; the leading idle cycle keeps back-to-back calls apart.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clk_sys);
    penable = 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 8) begin
      n++;
      @(posedge clk_sys);
    end
    if (pready !== 1'b1) begin
      failures++;
    end
    last_err = pslverr;
    @(negedge clk_sys);
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Read data is registered, so it is judged at the falling edge after the access edge.
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(prdata, e)
  endtask : rchk

  // One-cycle engine event, then time for flags and interrupts to land.
  task automatic pulse(input logic f, input logic s);
    @(negedge clk_sys);
    desc_fetch = f;
    stat_post = s;
    @(negedge clk_sys);
    desc_fetch = 1'b0;
    stat_post = 1'b0;
    @(negedge clk_sys);
  endtask : pulse

  task automatic t_reset();
    `CHK(func_count, NF)
    rchk(`DQ_OFS_SEVERITY, 32'h0);
    rchk(`DQ_OFS_ENABLE, 32'h0);
    rchk(`DQ_OFS_MASK, 32'h0);
    rchk(`DQ_OFS_STATUS, 32'h0);
    rchk(`DQ_OFS_FUNCS, {29'h0, NF});
    rchk(`DQ_OFS_BURST, 32'h8);
    rchk(8'h30, 32'h0);
    `CHK(last_err, 1'h1)
    wr(`DQ_OFS_FUNCS, 32'hFFFF_FFFB);
    rchk(`DQ_OFS_FUNCS, 32'h3);
    `CHK(func_count, 3'h3)
  endtask : t_reset

  // Reserved bits must read zero in every event register.
  task automatic t_regs();
    wr(`DQ_OFS_SEVERITY, 32'hFFFF_FFFF);
    rchk(`DQ_OFS_SEVERITY, `DQ_EV_VALID);
    wr(`DQ_OFS_MASK, 32'hFFFF_FFFF);
    rchk(`DQ_OFS_MASK, `DQ_EV_VALID);
    wr(`DQ_OFS_ENABLE, 32'hFFFF_FFFF);
    rchk(`DQ_OFS_ENABLE, `DQ_EV_VALID);
    rchk(`DQ_OFS_STATUS, 32'h22);
    wr(`DQ_OFS_ENABLE, 32'h0);
    wr(`DQ_OFS_SEVERITY, 32'h0);
    wr(`DQ_OFS_MASK, 32'h0);
  endtask : t_regs

  task automatic t_desc();
    pulse(1'b1, 1'b0);
    `CHK(queue_ptrs.desc_rptr, 8'h01)
    rchk(`DQ_OFS_STATUS, 32'h0);
    wr(`DQ_OFS_ENABLE, 32'h1);
    pulse(1'b1, 1'b0);
    rchk(`DQ_OFS_STATUS, 32'h1);
    `CHK({int_normal, int_critical}, 2'h2)
    wr(`DQ_OFS_SEVERITY, 32'h1);
    @(negedge clk_sys);
    `CHK({int_normal, int_critical}, 2'h1)
    wr(`DQ_OFS_MASK, 32'h1);
    @(negedge clk_sys);
    `CHK({int_normal, int_critical}, 2'h0)
    rchk(`DQ_OFS_STATUS, 32'h1);
    wr(`DQ_OFS_STATUS, 32'h1);
    rchk(`DQ_OFS_STATUS, 32'h0);
    pulse(1'b1, 1'b0);
    rchk(`DQ_OFS_STATUS, 32'h1);
    `CHK({int_normal, int_critical}, 2'h0)
    wr(`DQ_OFS_STATUS, 32'h1);
    wr(`DQ_OFS_ENABLE, 32'h6);
    wr(`DQ_OFS_DESC_PTR, 32'h2);
    rchk(`DQ_OFS_STATUS, 32'h4);
    wr(`DQ_OFS_DESC_PTR, 32'h3);
    rchk(`DQ_OFS_DESC_PTR, 32'h0003_0003);
    rchk(`DQ_OFS_STATUS, 32'h6);
    wr(`DQ_OFS_STATUS, 32'h6);
    rchk(`DQ_OFS_STATUS, 32'h2);
    wr(`DQ_OFS_ENABLE, 32'h0);
    rchk(`DQ_OFS_STATUS, 32'h0);
  endtask : t_desc

  // The bench plays the master, draining each entry so at most one is queued.
  task automatic t_stat();
    logic [7:0] wp;
    wp = 8'h00;
    wr(`DQ_OFS_ENABLE, 32'h70);
    rchk(`DQ_OFS_STATUS, 32'h20);
    for (int i = 0; i < 4; i++) begin
      pulse(1'b0, 1'b1);
      wp = (wp == 8'h03) ? 8'h00 : wp + 8'h01;
      `CHK(queue_ptrs.stat_wptr, wp)
      wr(`DQ_OFS_STAT_PTR, {24'h0, wp});
    end
    rchk(`DQ_OFS_STAT_PTR, 32'h0);
    rchk(`DQ_OFS_STATUS, 32'h30);
    wr(`DQ_OFS_STAT_PTR, 32'h1);
    rchk(`DQ_OFS_STATUS, 32'h70);
    wr(`DQ_OFS_STATUS, 32'h40);
    rchk(`DQ_OFS_STATUS, 32'h70);
    // A post lands on the very edge that clears its flag; the post must win.
    fork
      wr(`DQ_OFS_STATUS, 32'h10);
      begin
        repeat (2) @(negedge clk_sys);
        stat_post = 1'b1;
        @(negedge clk_sys);
        stat_post = 1'b0;
      end
    join
    rchk(`DQ_OFS_STATUS, 32'h70);
  endtask : t_stat

  // Every burst setting, with a request of two full chunks and a remainder.
  task automatic t_burst();
    logic [15:0] lim;
    int n;
    for (int k = 0; k < 7; k++) begin
      lim = 16'h4 << k;
      slow = k[0];
      wr(`DQ_OFS_BURST, 32'h1 << k);
      rchk(`DQ_OFS_BURST, 32'h1 << k);
      u_dma.got_q.delete();
      req_beats = 16'(2 * lim + 3);
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      `CHK({req_ready, burst_valid}, 2'h1)
      n = 0;
      while (u_dma.got_q.size() < 3 && n < 50) begin
        n++;
        @(negedge clk_sys);
      end
      `CHK(u_dma.got_q.size(), 3)
      `CHK({req_ready, burst_valid}, 2'h2)
      for (int i = 0; i < 3; i++) begin
        `CHK(u_dma.got_q[i], {(i == 2) ? 16'h3 : lim, i == 2})
      end
    end
  endtask : t_burst

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Main sequence: two reset cycles, then each scenario in turn.
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_regs();
    t_desc();
    t_stat();
    t_burst();
    final_report();
  end

  // The whole run needs a few hundred cycles; this limit is far above it.
  initial begin
    #1ms;
    failures++;
    final_report();
  end
endmodule : dma_queue_interrupt_csr_tb_top
